// >>> core/nfcpt_timers.sv
// nfc protocol timer unit: no-response, peer-field wait, general and wake-up timers
`timescale 1ns/10ps
`default_nettype none
module nfcpt_timers (
   // clock and reset
   input  wire logic                             i_clk,
   input  wire logic                             i_resetn,
   // configuration
   input  wire nfcpt_pkg::nfcpt_mode_t           i_mode,
   input  wire logic                             i_osc_en,
   input  wire logic                             i_nrt_step,
   input  wire logic                             i_nrt_uncond,
   input  wire logic                             i_nrt_nfc,
   input  wire logic [7:0]                       i_nrt_cfg_hi,
   input  wire logic [7:0]                       i_nrt_cfg_lo,
   input  wire logic [nfcpt_pkg::NFCPT_PPON_W-1:0] i_ppon_cfg,
   input  wire logic                             i_gp_trig_sel,
   input  wire logic [nfcpt_pkg::NFCPT_GP_W-1:0] i_gp_cfg,
   input  wire logic [nfcpt_pkg::NFCPT_WU_W-1:0] i_wu_cfg,
   // direct commands, one-cycle pulses
   input  wire logic                             i_cmd_start_nrt,
   input  wire logic                             i_cmd_stop_nrt,
   input  wire logic                             i_cmd_start_gp,
   input  wire logic                             i_cmd_start_wu,
   input  wire logic                             i_cmd_stop_all,
   // link events, asynchronous levels
   input  wire logic                             i_tx_active,
   input  wire logic                             i_rx_busy,
   input  wire logic                             i_ext_field,
   input  wire logic                             i_rc_tick,
   // host flag acknowledgement, one-cycle pulses
   input  wire logic                             i_txe_read,
   input  wire logic                             i_clr_nre,
   input  wire logic                             i_clr_ppon,
   input  wire logic                             i_clr_gpe,
   input  wire logic                             i_clr_wt,
   // status
   output logic                                  o_rx_on,
   output logic                                  o_rc_osc_on,
   output logic                                  o_nrt_running,
   output logic                                  o_gp_running,
   output logic                                  o_ppon_running,
   output logic                                  o_wu_running,
   output logic                                  o_tmp_enable,
   output logic                                  o_nre_irq,
   output logic                                  o_peer_field_wait_irq,
   output logic                                  o_gpe_irq,
   output logic                                  o_wakeup_timer_irq,
   output logic                                  o_irq
);
   import nfcpt_pkg::*;

   // pin levels pass two flops before use
   logic [3:0] sync_w;
   nfcpt_sync #(.W(4)) u_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_async  ({i_rc_tick, i_ext_field, i_rx_busy, i_tx_active}),
      .o_sync   (sync_w)
   );
   wire tx_w  = sync_w[0];
   wire rx_w  = sync_w[1];
   wire fld_w = sync_w[2];
   wire rct_w = sync_w[3];

   logic tx_q;
   logic rx_q;
   logic fld_q;
   logic rct_q;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         tx_q  <= 1'b0;
         rx_q  <= 1'b0;
         fld_q <= 1'b0;
         rct_q <= 1'b0;
      end else begin
         tx_q  <= tx_w;
         rx_q  <= rx_w;
         fld_q <= fld_w;
         rct_q <= rct_w;
      end
   end
   wire tx_end_w   = tx_q & ~tx_w;
   wire rx_start_w = ~rx_q & rx_w;
   wire rx_end_w   = rx_q & ~rx_w;
   wire fld_on_w   = ~fld_q & fld_w;
   wire rc_edge_w  = ~rct_q & rct_w;

   // mode decode
   wire m_reader_w = (i_mode == NFCPT_MODE_READER);
   wire m_active_w = (i_mode == NFCPT_MODE_ACT_INI) || (i_mode == NFCPT_MODE_ACT_TGT);
   wire m_brd_w    = (i_mode == NFCPT_MODE_BITRATE);
   wire m_pas_w    = (i_mode == NFCPT_MODE_PAS_TGT);
   wire m_wake_w   = (i_mode == NFCPT_MODE_WAKEUP);
   wire m_nfc_w    = m_active_w | m_brd_w | m_pas_w;
   // crystal timers halt in power-down
   wire xtal_w     = i_osc_en;

   // no-response timer prescaler
   logic [NFCPT_PRE_W-1:0] pre_q;
   logic                   nrt_run_w;
   logic                   nrt_start_w;
   wire [NFCPT_PRE_W-1:0]  pre_max_w = i_nrt_step ? NFCPT_PRE_LONG_MAX
                                                  : NFCPT_PRE_SHORT_MAX;
   wire nrt_tick_w = xtal_w && (pre_q == pre_max_w);
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         pre_q <= '0;
      end else if (nrt_start_w || !nrt_run_w || nrt_tick_w) begin
         pre_q <= '0;
      end else if (xtal_w) begin
         pre_q <= pre_q + NFCPT_PRE_W'(1);
      end
   end

   // general timer expiry used as own field-off point in active and bit-rate modes
   logic gp_exp_w;
   wire nrt_auto_w =
        (m_reader_w && tx_end_w)
      | ((m_active_w | m_brd_w) && !i_nrt_nfc && tx_end_w && gp_exp_w)
      | ((m_active_w | m_brd_w) && !i_nrt_nfc && gp_exp_w)
      | (m_active_w && i_nrt_nfc && fld_on_w);
   assign nrt_start_w = xtal_w && (i_cmd_start_nrt || nrt_auto_w);
   wire nrt_reply_stop_w = !i_nrt_uncond && rx_start_w;
   wire nrt_stop_w = i_cmd_stop_nrt
                   | (i_cmd_stop_all && !i_nrt_uncond)
                   | nrt_reply_stop_w
                   | !xtal_w;
   logic nrt_exp_w;
   nfcpt_down_timer #(.W(NFCPT_CNT_W)) u_nrt (
      .i_clk     (i_clk),
      .i_resetn  (i_resetn),
      .i_tick    (nrt_tick_w),
      .i_start   (nrt_start_w),
      .i_stop    (nrt_stop_w),
      .i_load    ({i_nrt_cfg_hi, i_nrt_cfg_lo}),
      .o_running (nrt_run_w),
      .o_expire  (nrt_exp_w)
   );

   // receiver enable: dropped on expiry unless a reply is in progress with i_nrt_uncond set
   logic rx_on_q;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rx_on_q <= 1'b1;
      end else if (nrt_exp_w && !(i_nrt_uncond && rx_w)) begin
         rx_on_q <= 1'b0;
      end else if (tx_w || nrt_start_w) begin
         rx_on_q <= 1'b1;
      end
   end

   // peer-field wait timer, gated by the transmit-end read
   logic txe_seen_q;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         txe_seen_q <= 1'b0;
      end else if (tx_end_w && m_nfc_w) begin
         txe_seen_q <= 1'b1;
      end else if (i_txe_read) begin
         txe_seen_q <= 1'b0;
      end
   end
   wire ppon_start_w = xtal_w && m_nfc_w && txe_seen_q && i_txe_read;
   wire ppon_stop_w  = fld_on_w || i_cmd_stop_all || !xtal_w || m_reader_w;
   logic ppon_run_w;
   logic ppon_exp_w;
   nfcpt_down_timer #(.W(NFCPT_PPON_W)) u_ppon (
      .i_clk     (i_clk),
      .i_resetn  (i_resetn),
      .i_tick    (nrt_tick_w | (xtal_w && !nrt_run_w)),
      .i_start   (ppon_start_w),
      .i_stop    (ppon_stop_w),
      .i_load    (i_ppon_cfg),
      .o_running (ppon_run_w),
      .o_expire  (ppon_exp_w)
   );

   // general purpose timer
   wire gp_trig_w = (i_gp_trig_sel == NFCPT_GP_TRIG_RX_START) ? rx_start_w : rx_end_w;
   wire gp_start_w = xtal_w && (i_cmd_start_gp || gp_trig_w || (m_active_w && tx_end_w));
   logic gp_run_w;
   nfcpt_down_timer #(.W(NFCPT_GP_W)) u_gp (
      .i_clk     (i_clk),
      .i_resetn  (i_resetn),
      .i_tick    (xtal_w),
      .i_start   (gp_start_w),
      .i_stop    (i_cmd_stop_all || !xtal_w),
      .i_load    (i_gp_cfg),
      .o_running (gp_run_w),
      .o_expire  (gp_exp_w)
   );

   // wake-up timer on rc ticks, alive in power-down
   logic rc_on_q;
   wire wu_start_w = i_cmd_start_wu && !m_wake_w;
   wire tmp_start_w = m_pas_w && fld_on_w && !rc_on_q;
   logic wu_run_w;
   logic wu_exp_w;
   nfcpt_down_timer #(.W(NFCPT_WU_W)) u_wu (
      .i_clk     (i_clk),
      .i_resetn  (i_resetn),
      .i_tick    (rc_on_q && rc_edge_w),
      .i_start   (wu_start_w || tmp_start_w),
      .i_stop    (i_cmd_stop_all),
      .i_load    (i_wu_cfg),
      .o_running (wu_run_w),
      .o_expire  (wu_exp_w)
   );
   logic tmp_en_q;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         rc_on_q  <= 1'b0;
         tmp_en_q <= 1'b0;
      end else begin
         if (wu_start_w || tmp_start_w) begin
            rc_on_q <= 1'b1;
         end else if (!wu_run_w) begin
            rc_on_q <= 1'b0;
         end
         if (tmp_start_w) begin
            tmp_en_q <= 1'b1;
         end else if (wu_exp_w || i_cmd_stop_all) begin
            tmp_en_q <= 1'b0;
         end
      end
   end

   // sticky flags: set wins over clear
   logic nre_q;
   logic ppf_q;
   logic gpe_q;
   logic wt_q;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         nre_q <= 1'b0;
         ppf_q <= 1'b0;
         gpe_q <= 1'b0;
         wt_q  <= 1'b0;
      end else begin
         nre_q <= nrt_exp_w  | (nre_q & ~i_clr_nre);
         ppf_q <= ppon_exp_w | (ppf_q & ~i_clr_ppon);
         gpe_q <= gp_exp_w   | (gpe_q & ~i_clr_gpe);
         wt_q  <= wu_exp_w   | (wt_q & ~i_clr_wt);
      end
   end

   assign o_rx_on               = rx_on_q;
   assign o_rc_osc_on           = rc_on_q;
   assign o_nrt_running         = nrt_run_w;
   assign o_gp_running          = gp_run_w;
   assign o_ppon_running        = ppon_run_w;
   assign o_wu_running          = wu_run_w;
   assign o_tmp_enable          = tmp_en_q;
   assign o_nre_irq             = nre_q;
   assign o_peer_field_wait_irq = ppf_q;
   assign o_gpe_irq             = gpe_q;
   assign o_wakeup_timer_irq    = wt_q;
   assign o_irq                 = nre_q | ppf_q | gpe_q | wt_q;
endmodule
`default_nettype wire

// >>> core/nfcpt_pkg.sv
// constants and types of the nfc protocol timer unit
package nfcpt_pkg;
   localparam int unsigned NFCPT_STEP_SHORT = 64;
   localparam int unsigned NFCPT_STEP_LONG  = 4096;
   localparam int unsigned NFCPT_PRE_W      = 12;
   localparam int unsigned NFCPT_CNT_W      = 16;
   localparam int unsigned NFCPT_GP_W       = 16;
   localparam int unsigned NFCPT_PPON_W     = 8;
   localparam int unsigned NFCPT_WU_W       = 8;
   localparam logic [NFCPT_PRE_W-1:0] NFCPT_PRE_SHORT_MAX = 12'h03F;
   localparam logic [NFCPT_PRE_W-1:0] NFCPT_PRE_LONG_MAX  = 12'hFFF;
   // operating modes, one-hot
   typedef enum logic [5:0] {
      NFCPT_MODE_READER  = 6'h01,
      NFCPT_MODE_ACT_INI = 6'h02,
      NFCPT_MODE_ACT_TGT = 6'h04,
      NFCPT_MODE_BITRATE = 6'h08,
      NFCPT_MODE_PAS_TGT = 6'h10,
      NFCPT_MODE_WAKEUP  = 6'h20
   } nfcpt_mode_t;
   localparam logic NFCPT_GP_TRIG_RX_START = 1'b0;
   localparam logic NFCPT_GP_TRIG_RX_END   = 1'b1;
endpackage

// >>> core/nfcpt_down_timer.sv
// generic start/stop countdown timer with expiry pulse
`timescale 1ns/10ps
`default_nettype none
module nfcpt_down_timer #(
   parameter int unsigned W = 16
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   // control
   input  wire logic         i_tick,
   input  wire logic         i_start,
   input  wire logic         i_stop,
   input  wire logic [W-1:0] i_load,
   // status
   output logic              o_running,
   output logic              o_expire
);
   logic [W-1:0] cnt_q;
   logic         run_q;
   logic         exp_q;
   wire          last_w = run_q && i_tick && (cnt_q <= W'(1));

   // start wins over stop so a restart in the stop cycle is kept
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         exp_q <= 1'b0;
      end else begin
         exp_q <= 1'b0;
         if (i_start) begin
            cnt_q <= i_load;
            run_q <= 1'b1;
         end else if (i_stop) begin
            run_q <= 1'b0;
         end else if (last_w) begin
            run_q <= 1'b0;
            exp_q <= 1'b1;
         end else if (run_q && i_tick) begin
            cnt_q <= cnt_q - W'(1);
         end
      end
   end

   assign o_running = run_q;
   assign o_expire  = exp_q;
endmodule
`default_nettype wire

// >>> core/nfcpt_sync.sv
// two-flop synchroniser for pin-side event levels
`timescale 1ns/10ps
`default_nettype none
module nfcpt_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic [W-1:0] i_async,
   output logic [W-1:0]      o_sync
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
      end
   end
   assign o_sync = s2_q;
endmodule
`default_nettype wire

// >>> test/nfcpt_timers_props.sv
// port assertions of the nfc protocol timer unit
`timescale 1ns/10ps
`default_nettype none
module nfcpt_timers_props (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // controls
   input wire logic i_osc_en,
   input wire logic i_nrt_uncond,
   input wire logic i_cmd_start_nrt,
   input wire logic i_cmd_stop_nrt,
   input wire logic i_cmd_start_gp,
   input wire logic i_cmd_stop_all,
   input wire logic i_clr_nre,
   // watched outputs
   input wire logic o_rx_on,
   input wire logic o_nrt_running,
   input wire logic o_gp_running,
   input wire logic o_nre_irq,
   input wire logic o_peer_field_wait_irq,
   input wire logic o_gpe_irq,
   input wire logic o_wakeup_timer_irq,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   a_nrt_cmd_start: assert property (i_cmd_start_nrt && i_osc_en |=> o_nrt_running)
      else $error("nrt start lost");
   a_nrt_cmd_stop: assert property (i_cmd_stop_nrt && !i_cmd_start_nrt && i_osc_en
      |=> !o_nrt_running) else $error("nrt stop ignored");
   a_gp_stop_all: assert property (i_cmd_stop_all && !i_cmd_start_gp && i_osc_en
      |=> !o_gp_running) else $error("gp survived stop all");
   // an expiry in the stop cycle ends the run, its flag shows one cycle later
   a_nrt_uncond_hold: assert property (i_cmd_stop_all && !i_cmd_stop_nrt && i_nrt_uncond
      && i_osc_en && o_nrt_running |-> ##1 o_nrt_running or ##2 o_nre_irq)
      else $error("uncond nrt halted");
   a_nre_rx_off: assert property ($rose(o_nre_irq) && !i_nrt_uncond |-> !o_rx_on)
      else $error("receiver left on");
   a_irq_merge: assert property (o_irq == (o_nre_irq || o_peer_field_wait_irq
      || o_gpe_irq || o_wakeup_timer_irq)) else $error("irq line wrong");
   // a halt by stop all or power-down is the only silent end of the gp timer
   a_gp_expiry_flag: assert property ($fell(o_gp_running) && !$past(i_cmd_stop_all)
      && $past(i_osc_en) |=> o_gpe_irq) else $error("gp expiry without flag");
   a_nre_flag_hold: assert property (o_nre_irq && !i_clr_nre |=> o_nre_irq)
      else $error("nre flag dropped");
   c_nre_set: cover property ($rose(o_nre_irq));
   c_gpe_set: cover property ($rose(o_gpe_irq));
   c_wt_set: cover property ($rose(o_wakeup_timer_irq));
endmodule
bind nfcpt_timers nfcpt_timers_props nfcpt_timers_props_inst (.i_clk, .i_resetn, .i_osc_en,
   .i_nrt_uncond, .i_cmd_start_nrt, .i_cmd_stop_nrt, .i_cmd_start_gp, .i_cmd_stop_all,
   .i_clr_nre, .o_rx_on, .o_nrt_running, .o_gp_running, .o_nre_irq,
   .o_peer_field_wait_irq, .o_gpe_irq, .o_wakeup_timer_irq, .o_irq);
`default_nettype wire

// >>> test/nfcpt_host.sv
// host model issuing direct commands and flag acknowledgements
`timescale 1ns/10ps
`default_nettype none
module nfcpt_host (
   // clock
   input  wire logic  i_clk,
   // pulses towards the timer unit
   output logic [4:0] o_cmd,
   output logic [4:0] o_ack
);
   initial {o_cmd, o_ack} = 10'h000;
   // idle edge after each pulse so back-to-back calls never merge
   task automatic pulse(input logic [9:0] v);
      {o_cmd, o_ack} = v;
      @(posedge i_clk);
      #1 {o_cmd, o_ack} = 10'h000;
      @(posedge i_clk);
      #1;
   endtask
   // transmit-end flag first, else the peer-field wait never starts
   task automatic service();
      pulse(10'h010);
      pulse(10'h002);
   endtask
endmodule
`default_nettype wire

// >>> test/tb_nfcpt_timers.sv
// self-checking bench of the nfc protocol timer unit
`timescale 1ns/10ps
`default_nettype none
module tb_nfcpt_timers;
   import nfcpt_pkg::*;
   localparam logic [3:0] EX = 4'b1001;
   logic        i_clk = 1'b0;
   logic        i_resetn = 1'b0;
   nfcpt_mode_t mode = NFCPT_MODE_READER;
   nfcpt_mode_t md [4] = '{NFCPT_MODE_READER, NFCPT_MODE_PAS_TGT, NFCPT_MODE_BITRATE,
                           NFCPT_MODE_ACT_INI};
   logic        osc = 1'b1, step = 1'b0, unc = 1'b0, nfc = 1'b1, trig = 1'b0;
   logic        tx = 1'b0, rxb = 1'b0, fld = 1'b0, rc = 1'b0;
   logic [15:0] ncnt = 16'h0004, gcnt = 16'h0020;
   logic [7:0]  pcfg = 8'h40, wcfg = 8'h03;
   logic [4:0]  cmd, ack;
   logic        rx_on, osc_on, tmp, irq;
   wire  [3:0]  run, flg;
   logic [3:0]  flg_q = 4'h0;
   logic [3:0]  q [$];
   logic [31:0] lfsr = 32'hC624E947;
   int          err_count = 0, n_compared = 0, n, t;
   always #4 i_clk = ~i_clk;
   always begin
      repeat (5) @(posedge i_clk);
      #1 rc = ~rc;
   end
   nfcpt_host nfcpt_host_inst (.i_clk, .o_cmd(cmd), .o_ack(ack));
   nfcpt_timers nfcpt_timers_inst (.i_clk, .i_resetn, .i_mode(mode), .i_osc_en(osc),
      .i_nrt_step(step), .i_nrt_uncond(unc), .i_nrt_nfc(nfc), .i_nrt_cfg_hi(ncnt[15:8]),
      .i_nrt_cfg_lo(ncnt[7:0]), .i_ppon_cfg(pcfg), .i_gp_trig_sel(trig), .i_gp_cfg(gcnt),
      .i_wu_cfg(wcfg), .i_cmd_start_nrt(cmd[4]), .i_cmd_stop_nrt(cmd[3]),
      .i_cmd_start_gp(cmd[2]), .i_cmd_start_wu(cmd[1]), .i_cmd_stop_all(cmd[0]),
      .i_tx_active(tx), .i_rx_busy(rxb), .i_ext_field(fld), .i_rc_tick(rc),
      .i_txe_read(ack[4]), .i_clr_nre(ack[3]), .i_clr_ppon(ack[2]), .i_clr_gpe(ack[1]),
      .i_clr_wt(ack[0]), .o_rx_on(rx_on), .o_rc_osc_on(osc_on), .o_nrt_running(run[3]),
      .o_gp_running(run[1]), .o_ppon_running(run[2]), .o_wu_running(run[0]),
      .o_tmp_enable(tmp), .o_nre_irq(flg[3]), .o_peer_field_wait_irq(flg[2]),
      .o_gpe_irq(flg[1]), .o_wakeup_timer_irq(flg[0]), .o_irq(irq));
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [3:0] e, input logic [3:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task automatic hp(input logic [9:0] v);
      nfcpt_host_inst.pulse(v);
   endtask
   task automatic rst();
      i_resetn = 1'b0;
      cyc(2);
      i_resetn = 1'b1;
   endtask
   task automatic wait_irq(input logic [3:0] m);
      n = 0;
      while ((flg & m) == 4'h0) begin
         cyc(1);
         n++;
         if (n > 30000) begin
            err_count++;
            test_done();
         end
      end
   endtask
   // each newly raised flag must match the oldest note
   always @(posedge i_clk) begin
      flg_q <= flg;
      if (i_resetn && (flg & ~flg_q) != 4'h0)
         chk(q.size() > 0 ? q.pop_front() : 4'h0, flg & ~flg_q);
   end
   initial begin
      cyc(12);
      i_resetn = 1'b1;
      // peer-field wait kept longer than the gp timer so flags rise in a known order
      lfsr = nxt(lfsr);
      pcfg = 8'h40 + {3'h0, lfsr[4:0]};
      wcfg = 8'h02 + {6'h0, lfsr[6:5]};
      for (int s = 0; s < 2; s++) begin
         lfsr = nxt(lfsr);
         ncnt = 16'h0002 + {14'h0, lfsr[1:0]};
         step = s[0];
         t = s ? NFCPT_STEP_LONG : NFCPT_STEP_SHORT;
         q.push_back(4'h8);
         hp(10'h200);
         wait_irq(4'h8);
         chk(4'h1, {3'h0, n >= (ncnt - 1) * t && n <= ncnt * t + 8});
         chk(4'h0, {run[3:1], rx_on});
         hp(10'h008);
      end
      step = 1'b0;
      ncnt = 16'h0004;
      q.push_back(4'h8);
      hp(10'h200);
      cyc(150);
      hp(10'h200);
      wait_irq(4'h8);
      chk(4'h1, {3'h0, n >= 192});
      hp(10'h008);
      rst();
      hp(10'h200);
      cyc(20);
      q.push_back(4'h2);
      rxb = 1'b1;
      cyc(6);
      chk(4'h2, run);
      wait_irq(4'h2);
      hp(10'h002);
      q.push_back(4'h2);
      trig = 1'b1;
      rxb = 1'b0;
      wait_irq(4'h2);
      hp(10'h002);
      for (int k = 0; k < 2; k++) begin
         hp(10'h280);
         cyc(4);
         hp(k ? 10'h100 : 10'h020);
         chk(k ? 4'h2 : 4'h0, run);
      end
      hp(10'h020);
      unc = 1'b1;
      for (int r = 1; r >= 0; r--) begin
         rst();
         rxb = r[0];
         hp(10'h200);
         hp(10'h020);
         chk(4'h8, run);
         q.push_back(4'h8);
         wait_irq(4'h8);
         chk({3'h0, r[0]}, {3'h0, rx_on});
         hp(10'h008);
         rxb = 1'b0;
         cyc(5);
         hp(10'h020);
      end
      unc = 1'b0;
      for (int i = 0; i < 4; i++) begin
         mode = md[i];
         tx = i < 2;
         cyc(4);
         tx = 1'b0;
         fld = i > 1;
         cyc(5);
         chk({3'h0, EX[i]}, {3'h0, run[3]});
         fld = 1'b0;
         hp(10'h020);
      end
      nfc = 1'b0;
      q.push_back(4'h2);
      hp(10'h080);
      wait_irq(4'h2);
      cyc(4);
      chk(4'h8, run & 4'h8);
      hp(10'h022);
      nfc = 1'b1;
      for (int f = 1; f >= 0; f--) begin
         tx = 1'b1;
         cyc(4);
         tx = 1'b0;
         cyc(4);
         nfcpt_host_inst.service();
         chk(4'h4, run & 4'h4);
         // tx end in active mode also runs the gp timer, which expires first
         if (f == 0) begin
            q.push_back(4'h2);
            q.push_back(4'h4);
         end
         fld = f[0];
         cyc(8);
         if (f == 0)
            wait_irq(4'h4);
         chk(4'h0, run & 4'h4);
         hp(10'h026);
         fld = 1'b0;
      end
      mode = NFCPT_MODE_READER;
      lfsr = nxt(lfsr);
      gcnt = 16'h0040 + {11'h0, lfsr[4:0]};
      q.push_back(4'h2);
      hp(10'h080);
      cyc(40);
      hp(10'h080);
      wait_irq(4'h2);
      chk(4'h1, {3'h0, n >= gcnt - 8 && n <= gcnt + 4});
      hp(10'h002);
      osc = 1'b0;
      hp(10'h200);
      chk(4'h0, run);
      q.push_back(4'h1);
      hp(10'h040);
      chk(4'h9, {osc_on, 2'h0, run[0]});
      wait_irq(4'h1);
      hp(10'h001);
      osc = 1'b1;
      mode = NFCPT_MODE_WAKEUP;
      hp(10'h040);
      chk(4'h0, run);
      mode = NFCPT_MODE_PAS_TGT;
      q.push_back(4'h1);
      fld = 1'b1;
      cyc(5);
      chk(4'h3, {2'h0, tmp, run[0]});
      wait_irq(4'h1);
      cyc(2);
      chk(4'h0, {3'h0, tmp});
      hp(10'h001);
      fld = 1'b0;
      chk(4'h0, 4'(q.size()));
      test_done();
   end
endmodule
`default_nettype wire
